// *** core/cpr_regs.sv ***
// cpr_regs: power-path, tracking and temperature-threshold registers.
// assumes: host reaches registers by a byte write/read port on clk;
// watchdog expiry, adapter plug-in and sweep completion are same-clock pulses.
//
// Function
// - writing defaults-restore bit reloads all registers, then bit self-clears
// - input load enable drives load; reset by register reset and watchdog
// - valid sync detection on sync pin clears pulse-skip enable
// - host may set pulse-skip again; it then holds despite sync present
// - pulse-skip bit resets to one; zero means fixed-frequency light load
// - sweep trigger starts sweep, restarts timers, clears on sweep done
// - perturb-observe period codes: off, 0.5 s, 1 s, 10 s; reset 01b
// - sweep period codes: 3, 10, 15, 20 minutes; reset 00b
// - tracking enabled blocks host measurement-control writes; default off
// - hot threshold select codes 50 to 65 C; reset 10b
// - warm threshold select codes 40 to 55 C; reset 01b
// - cool threshold select codes 5 to 20 C; reset 01b
// - cold threshold select codes -10 to 5 C; reset 10b
// - watchdog kick bit restarts timer, then device clears it
`timescale 1ns/10ps
module cpr_regs
    import cpr_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst_b,
    input  wire logic       clkEn,
    input  wire logic       regWrite,
    input  wire logic [7:0] regAddr,
    input  wire logic [7:0] regWdata,
    output logic      [7:0] regRdata,
    input  wire logic       watchdogExpired,
    input  wire logic       adapterPlugIn,
    input  wire logic       sweepComplete,
    input  wire logic       switchingSyncPin,
    input  wire logic       measCtrlWriteReq,
    output logic            measCtrlWriteAllow,
    output logic            watchdogRestart,
    output logic            sweepStart,
    output logic            sweepActive,
    output logic            inputLoadEnable,
    output logic            lightLoadPulseSkipEnable,
    output logic            reversePowerEnable,
    output logic      [1:0] perturbObservePeriod,
    output logic      [1:0] panelSweepPeriod,
    output logic            maxPowerTrackingEnable,
    output logic      [1:0] hotThresholdSelect,
    output logic      [1:0] warmThresholdSelect,
    output logic      [1:0] coolThresholdSelect,
    output logic      [1:0] coldThresholdSelect
);

    // ------------------------------------------------------------
    // storage and sync pin
    // ------------------------------------------------------------
    logic [7:0] pathReg;
    logic [7:0] trackReg;
    logic [7:0] tempReg;
    logic       kick;
    logic [7:0] next_pathReg;
    logic [7:0] next_trackReg;
    logic [7:0] next_tempReg;
    logic       next_kick;
    cpr_sweep_t sweepState;
    cpr_sweep_t next_sweepState;
    logic       sweepFresh;
    logic       next_sweepFresh;
    logic       syncValid;
    logic       syncRise;

    cpr_pin_sync u_sync (
        .clk      (clk),
        .rst_b    (rst_b),
        .clkEn    (clkEn),
        .pinIn    (switchingSyncPin),
        .pinLevel (syncValid),
        .pinRise  (syncRise)
    );

    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        hit = regWrite && (a == ofs);
    endfunction : hit

    logic wrPath;
    logic wrTrack;
    logic wrTemp;
    logic wrCtrl;
    logic restore;
    assign wrPath  = hit(regAddr, CPR_OFS_PATH);
    assign wrTrack = hit(regAddr, CPR_OFS_TRACK);
    assign wrTemp  = hit(regAddr, CPR_OFS_TEMP);
    assign wrCtrl  = hit(regAddr, CPR_OFS_WDCTRL);
    assign restore = wrPath && regWdata[CPR_BIT_DEFAULTS];

    // ------------------------------------------------------------
    // next-value logic
    // ------------------------------------------------------------
    always_comb begin
        next_pathReg    = pathReg;
        next_trackReg   = trackReg;
        next_tempReg    = tempReg;
        next_kick       = kick;
        next_sweepState = sweepState;
        next_sweepFresh = sweepFresh;
        if (clkEn) begin
            // kick drops only on a running clock; a frozen bank keeps it
            next_kick = 1'b0;
            // masked writes keep reserved bits zero
            if (wrPath) begin
                next_pathReg = regWdata & CPR_MASK_PATH;
            end
            if (wrTrack) begin
                next_trackReg = regWdata & CPR_MASK_TRACK;
            end
            if (wrTemp) begin
                next_tempReg = regWdata & CPR_MASK_TEMP;
            end
            // kick held one cycle then cleared
            if (wrCtrl) begin
                next_kick = regWdata[CPR_BIT_KICK];
            end
            // sync edge clears pulse-skip; same-cycle host write wins
            if (syncRise && !wrPath) begin
                next_pathReg[CPR_BIT_PULSESKIP] = 1'b0;
            end
            if (watchdogExpired) begin
                next_pathReg[CPR_BIT_INLOAD]  = 1'b0;
                next_pathReg[CPR_BIT_REVERSE] = 1'b0;
            end
            if (adapterPlugIn) begin
                next_pathReg[CPR_BIT_REVERSE] = 1'b0;
            end
            case (sweepState)
                CPR_SWP_IDLE: begin
                    if (next_trackReg[CPR_BIT_SWEEP]) begin
                        next_sweepState = CPR_SWP_RUN;
                    end
                end
                CPR_SWP_RUN: begin
                    if (sweepComplete) begin
                        next_sweepState = CPR_SWP_DONE;
                        next_trackReg[CPR_BIT_SWEEP] = 1'b0;
                    end else begin
                        next_trackReg[CPR_BIT_SWEEP] = 1'b1;
                    end
                end
                CPR_SWP_DONE: begin
                    next_sweepState = CPR_SWP_IDLE;
                end
                default: begin
                    next_sweepState = CPR_SWP_IDLE;
                end
            endcase
            // start pulse marks the first run cycle; registered so
            // it cannot glitch with the write data that launched it
            next_sweepFresh = (sweepState == CPR_SWP_IDLE) && (next_sweepState == CPR_SWP_RUN);
            // restore overrides everything, bit reads back zero
            if (restore) begin
                next_pathReg    = CPR_RST_PATH;
                next_trackReg   = CPR_RST_TRACK;
                next_tempReg    = CPR_RST_TEMP;
                next_kick       = 1'b0;
                next_sweepState = CPR_SWP_IDLE;
                next_sweepFresh = 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            pathReg    <= CPR_RST_PATH;
            trackReg   <= CPR_RST_TRACK;
            tempReg    <= CPR_RST_TEMP;
            kick       <= 1'b0;
            sweepState <= CPR_SWP_IDLE;
            sweepFresh <= 1'b0;
        end else begin
            pathReg    <= next_pathReg;
            trackReg   <= next_trackReg;
            tempReg    <= next_tempReg;
            kick       <= next_kick;
            sweepState <= next_sweepState;
            sweepFresh <= next_sweepFresh;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    always_comb begin
        case (regAddr)
            CPR_OFS_PATH:   regRdata = pathReg;
            CPR_OFS_TRACK:  regRdata = trackReg;
            CPR_OFS_TEMP:   regRdata = tempReg;
            CPR_OFS_WDCTRL: regRdata = {2'h0, kick, 5'h00};
            default:        regRdata = 8'h00;
        endcase
    end

    assign inputLoadEnable          = pathReg[CPR_BIT_INLOAD];
    // bit value alone selects mode, sync level not consulted
    assign lightLoadPulseSkipEnable = pathReg[CPR_BIT_PULSESKIP];
    assign reversePowerEnable       = pathReg[CPR_BIT_REVERSE];
    assign perturbObservePeriod     = trackReg[CPR_POS_PERTURB +: 2];
    assign panelSweepPeriod         = trackReg[CPR_POS_SWEEPPER +: 2];
    assign maxPowerTrackingEnable   = trackReg[CPR_BIT_TRACK];
    assign hotThresholdSelect       = tempReg[CPR_POS_HOT +: 2];
    assign warmThresholdSelect      = tempReg[CPR_POS_WARM +: 2];
    assign coolThresholdSelect      = tempReg[CPR_POS_COOL +: 2];
    assign coldThresholdSelect      = tempReg[CPR_POS_COLD +: 2];
    assign measCtrlWriteAllow       = measCtrlWriteReq && !trackReg[CPR_BIT_TRACK];
    assign watchdogRestart          = kick;
    // one-cycle start, tracking timers restart from it
    assign sweepStart               = sweepFresh;
    assign sweepActive              = (sweepState == CPR_SWP_RUN);

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    sequence restoreWrite;
        clkEn && restore;
    endsequence

    sequence sweepTrigger;
        clkEn && sweepState == CPR_SWP_IDLE && wrTrack && !restore && regWdata[CPR_BIT_SWEEP];
    endsequence

    sequence sweepDrop;
        !trackReg[CPR_BIT_SWEEP] && sweepState == CPR_SWP_DONE;
    endsequence

    chk_restore_defaults: assert property (
        restoreWrite |=> pathReg == CPR_RST_PATH && trackReg == CPR_RST_TRACK
        && tempReg == CPR_RST_TEMP)
        else $error("defaults not restored");
    chk_load_watchdog: assert property (
        clkEn && watchdogExpired && !restore |=> !inputLoadEnable)
        else $error("load not cleared by watchdog");
    chk_sync_clear: assert property (
        clkEn && syncRise && !wrPath |=> !lightLoadPulseSkipEnable)
        else $error("pulse skip not cleared by sync");
    chk_skip_force: assert property (
        clkEn && wrPath && !restore && regWdata[CPR_BIT_PULSESKIP]
        |=> lightLoadPulseSkipEnable)
        else $error("host could not force pulse skip");
    chk_skip_hold: assert property (
        clkEn && syncValid && !syncRise && !wrPath && lightLoadPulseSkipEnable
        |=> lightLoadPulseSkipEnable)
        else $error("pulse skip dropped under steady sync");

    // ------------------------------------------------------------
    // sweep, measurement, kick, reverse and reserved-bit checks
    // ------------------------------------------------------------
    chk_sweep_start: assert property (
        sweepTrigger |=> sweepStart && sweepActive && trackReg[CPR_BIT_SWEEP])
        else $error("sweep not started");
    chk_sweep_hold: assert property (
        clkEn && sweepActive && !sweepComplete && !restore
        |=> sweepActive && !sweepStart && trackReg[CPR_BIT_SWEEP])
        else $error("sweep dropped early");
    chk_sweep_done: assert property (
        clkEn && sweepActive && sweepComplete && !restore
        |=> sweepDrop ##1 (sweepState == CPR_SWP_IDLE || !$past(clkEn)))
        else $error("sweep trigger not cleared");
    chk_sweep_idle: assert property (
        clkEn && sweepState == CPR_SWP_DONE |=> sweepState == CPR_SWP_IDLE)
        else $error("sweep did not return to idle");
    chk_meas_block: assert property (
        maxPowerTrackingEnable |-> !measCtrlWriteAllow)
        else $error("measurement write passed while tracking");
    chk_meas_open: assert property (
        measCtrlWriteReq && !maxPowerTrackingEnable |-> measCtrlWriteAllow)
        else $error("measurement write blocked while idle");
    chk_kick_clear: assert property (
        clkEn && kick && !(wrCtrl && regWdata[CPR_BIT_KICK]) |=> !kick)
        else $error("kick not cleared");
    chk_kick_frozen: assert property (
        !clkEn |=> $stable(kick))
        else $error("kick moved while frozen");
    chk_reverse_plug: assert property (
        clkEn && adapterPlugIn |=> !reversePowerEnable)
        else $error("reverse not cleared by plug-in");
    chk_reserved_zero: assert property (
        (pathReg & ~CPR_MASK_PATH) == 8'h00 && (trackReg & ~CPR_MASK_TRACK) == 8'h00)
        else $error("reserved bit set");

endmodule : cpr_regs

// *** core/cpr_pkg.sv ***
// cpr_pkg: offsets, field positions, reset values and codes for the
// power-path, tracking and temperature-threshold register slice.
// assumes: byte-wide registers reached by an 8-bit address.
package cpr_pkg;

    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] CPR_OFS_PATH    = 8'h19;
    localparam logic [7:0] CPR_OFS_TRACK   = 8'h1a;
    localparam logic [7:0] CPR_OFS_TEMP    = 8'h1b;
    localparam logic [7:0] CPR_OFS_WDCTRL  = 8'h17;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [7:0] CPR_RST_PATH    = 8'h20;
    localparam logic [7:0] CPR_RST_TRACK   = 8'h20;
    localparam logic [7:0] CPR_RST_TEMP    = 8'h96;

    // ------------------------------------------------------------
    // writable masks, reserved bits clear
    // ------------------------------------------------------------
    localparam logic [7:0] CPR_MASK_PATH   = 8'he1;
    localparam logic [7:0] CPR_MASK_TRACK  = 8'he7;
    localparam logic [7:0] CPR_MASK_TEMP   = 8'hff;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int CPR_BIT_DEFAULTS   = 7;
    localparam int CPR_BIT_INLOAD     = 6;
    localparam int CPR_BIT_PULSESKIP  = 5;
    localparam int CPR_BIT_REVERSE    = 0;
    localparam int CPR_BIT_SWEEP      = 7;
    localparam int CPR_POS_PERTURB    = 5;
    localparam int CPR_POS_SWEEPPER   = 1;
    localparam int CPR_BIT_TRACK      = 0;
    localparam int CPR_POS_HOT        = 6;
    localparam int CPR_POS_WARM       = 4;
    localparam int CPR_POS_COOL       = 2;
    localparam int CPR_POS_COLD       = 0;
    localparam int CPR_BIT_KICK       = 5;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CPR_CLK_MHZ        = 50;
    localparam int CPR_SYNC_STAGES    = 3;

    typedef enum logic [2:0] {
        CPR_SWP_IDLE = 3'b001,
        CPR_SWP_RUN  = 3'b010,
        CPR_SWP_DONE = 3'b100
    } cpr_sweep_t;

endpackage : cpr_pkg

// *** core/cpr_pin_sync.sv ***
// cpr_pin_sync: three-stage synchroniser for an asynchronous pin.
// assumes: one clock, clock enable freezes the stages.
`timescale 1ns/10ps
module cpr_pin_sync
    import cpr_pkg::*;
(
    input  wire logic clk,
    input  wire logic rst_b,
    input  wire logic clkEn,
    input  wire logic pinIn,
    output logic      pinLevel,
    output logic      pinRise
);
    logic [CPR_SYNC_STAGES-1:0] stage;
    logic [CPR_SYNC_STAGES-1:0] next_stage;
    logic                       next_pinLevel;

    // level moves only when stages two and three agree
    always_comb begin
        next_stage    = stage;
        next_pinLevel = pinLevel;
        if (clkEn) begin
            next_stage = {stage[1:0], pinIn};
            if (stage[1] == stage[2]) begin
                next_pinLevel = stage[2];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            stage    <= '0;
            pinLevel <= 1'b0;
        end else begin
            stage    <= next_stage;
            pinLevel <= next_pinLevel;
        end
    end

    assign pinRise = clkEn && !pinLevel && next_pinLevel;

endmodule : cpr_pin_sync

// *** verification/cpr_host_model.sv ***
// cpr_host_model: host side of the byte register port.
// assumes: shares clk with the bank; one transfer at a time.
`timescale 1ns/10ps
module cpr_host_model
    import cpr_pkg::*;
(
    input  wire logic       clk,
    input  wire logic [7:0] regRdata,
    output logic            regWrite,
    output logic      [7:0] regAddr,
    output logic      [7:0] regWdata
);
    // ------------------------------------------------------------
    // idle bus
    // ------------------------------------------------------------
    initial begin
        regWrite = 1'b0;
        regAddr  = 8'h00;
        regWdata = 8'h00;
    end

    // ------------------------------------------------------------
    // transfers
    // ------------------------------------------------------------
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        regWrite <= 1'b1;
        regAddr  <= a;
        regWdata <= d;
        @(posedge clk);
        regWrite <= 1'b0;
        // released data inverted, never a stale copy
        regWdata <= ~d;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        regAddr <= a;
        #1 d = regRdata;
    endtask : rd

    task automatic kick();
        wr(CPR_OFS_WDCTRL, 8'h20);
    endtask : kick

    task automatic tune(input int termMa);
        wr(CPR_OFS_PATH, (termMa < 2000) ? 8'h00 : 8'h20);
    endtask : tune
endmodule : cpr_host_model

// *** verification/charger_power_path_mppt_ts_regs_tb_top.sv ***
// bench for the power-path, tracking and threshold registers.
// assumes: host model drives the register port; bench drives side inputs.
`timescale 1ns/10ps
module charger_power_path_mppt_ts_regs_tb_top
    import cpr_pkg::*;
;
    logic       clk, rst_b, clkEn, regWrite, watchdogExpired, adapterPlugIn;
    logic       sweepComplete, switchingSyncPin, measCtrlWriteReq, measCtrlWriteAllow;
    logic       watchdogRestart, sweepStart, sweepActive, inputLoadEnable;
    logic       lightLoadPulseSkipEnable, reversePowerEnable, maxPowerTrackingEnable;
    logic [7:0] regAddr, regWdata, regRdata;
    logic [1:0] perturbObservePeriod, panelSweepPeriod, hotThresholdSelect;
    logic [1:0] warmThresholdSelect, coolThresholdSelect, coldThresholdSelect;
    int         fail_count, samples_checked;
    // rows: address, write data, expected read
    localparam logic [23:0] ROWS [12] = '{24'h197f61, 24'h191e00, 24'h1a7f67,
        24'h1a1800, 24'h1a2222, 24'h1a4444, 24'h1a6666, 24'h1b0000, 24'h1b5555,
        24'h1baaaa, 24'h1bffff, 24'h30ff00};

    // ------------------------------------------------------------
    // design and host
    // ------------------------------------------------------------
    cpr_regs i_dut (.clk, .rst_b, .clkEn, .regWrite, .regAddr, .regWdata, .regRdata,
        .watchdogExpired, .adapterPlugIn, .sweepComplete, .switchingSyncPin,
        .measCtrlWriteReq, .measCtrlWriteAllow, .watchdogRestart, .sweepStart,
        .sweepActive, .inputLoadEnable, .lightLoadPulseSkipEnable, .reversePowerEnable,
        .perturbObservePeriod, .panelSweepPeriod, .maxPowerTrackingEnable,
        .hotThresholdSelect, .warmThresholdSelect, .coolThresholdSelect,
        .coldThresholdSelect);
    cpr_host_model i_host (.clk, .regRdata, .regWrite, .regAddr, .regWdata);

    always #10 clk = ~clk;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
        samples_checked++;
        if (s !== e) begin
            $display("[FAIL] %s expected %h seen %h", n, e, s);
            fail_count++;
        end
    endtask : chk

    task automatic rc(input string n, input logic [7:0] a, input logic [7:0] e);
        logic [7:0] d;
        i_host.rd(a, d);
        chk(n, e, d);
    endtask : rc

    function automatic logic [7:0] pins(input logic [7:0] a);
        case (a)
            CPR_OFS_PATH: return {1'b0, inputLoadEnable, lightLoadPulseSkipEnable,
                4'h0, reversePowerEnable};
            CPR_OFS_TRACK: return {sweepActive, perturbObservePeriod, 2'b00,
                panelSweepPeriod, maxPowerTrackingEnable};
            CPR_OFS_TEMP: return {hotThresholdSelect, warmThresholdSelect,
                coolThresholdSelect, coldThresholdSelect};
            default: return 8'h00;
        endcase
    endfunction : pins

    task automatic summarize();
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : summarize

    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial begin
        clk = 1'b0;
        rst_b = 1'b0;
        clkEn = 1'b1;
        watchdogExpired = 1'b0;
        adapterPlugIn = 1'b0;
        sweepComplete = 1'b0;
        switchingSyncPin = 1'b0;
        measCtrlWriteReq = 1'b0;
        repeat (16) @(posedge clk);
        rst_b <= 1'b1;
        rc("path rst", CPR_OFS_PATH, 8'h20);
        rc("track rst", CPR_OFS_TRACK, 8'h20);
        rc("temp rst", CPR_OFS_TEMP, 8'h96);
        foreach (ROWS[i]) begin
            i_host.wr(ROWS[i][23:16], ROWS[i][15:8]);
            rc("row read", ROWS[i][23:16], ROWS[i][7:0]);
            chk("row pins", ROWS[i][7:0], pins(ROWS[i][23:16]));
        end
        @(posedge clk);
        measCtrlWriteReq <= 1'b1;
        i_host.wr(CPR_OFS_TRACK, 8'h01);
        #1 chk("meas blocked", 8'h00, {7'h0, measCtrlWriteAllow});
        i_host.wr(CPR_OFS_TRACK, 8'h00);
        #1 chk("meas open", 8'h01, {7'h0, measCtrlWriteAllow});
        i_host.wr(CPR_OFS_PATH, 8'h41);
        i_host.wr(CPR_OFS_TEMP, 8'h00);
        i_host.wr(CPR_OFS_PATH, 8'h80);
        rc("restore path", CPR_OFS_PATH, 8'h20);
        rc("restore track", CPR_OFS_TRACK, 8'h20);
        rc("restore temp", CPR_OFS_TEMP, 8'h96);
        i_host.wr(CPR_OFS_PATH, 8'h61);
        @(posedge clk);
        watchdogExpired <= 1'b1;
        @(posedge clk);
        watchdogExpired <= 1'b0;
        rc("wd clear", CPR_OFS_PATH, 8'h20);
        i_host.wr(CPR_OFS_PATH, 8'h61);
        @(posedge clk);
        adapterPlugIn <= 1'b1;
        @(posedge clk);
        adapterPlugIn <= 1'b0;
        rc("plug clear", CPR_OFS_PATH, 8'h60);
        i_host.tune(3000);
        @(posedge clk);
        switchingSyncPin <= 1'b1;
        repeat (6) @(posedge clk);
        rc("sync clear", CPR_OFS_PATH, 8'h00);
        i_host.tune(3000);
        repeat (6) @(posedge clk);
        rc("sync held", CPR_OFS_PATH, 8'h20);
        i_host.tune(1500);
        rc("low term", CPR_OFS_PATH, 8'h00);
        switchingSyncPin <= 1'b0;
        i_host.wr(CPR_OFS_TRACK, 8'h00);
        i_host.wr(CPR_OFS_TRACK, 8'h80);
        #1 chk("sweep go", 8'h03, {6'h0, sweepStart, sweepActive});
        i_host.wr(CPR_OFS_TRACK, 8'h00);
        rc("sweep kept", CPR_OFS_TRACK, 8'h80);
        @(posedge clk);
        sweepComplete <= 1'b1;
        @(posedge clk);
        sweepComplete <= 1'b0;
        #1 chk("sweep end", 8'h00, {7'h0, sweepActive});
        rc("sweep bit", CPR_OFS_TRACK, 8'h00);
        i_host.kick();
        #1 chk("kick go", 8'h01, {7'h0, watchdogRestart});
        rc("kick bit", CPR_OFS_WDCTRL, 8'h00);
        chk("kick end", 8'h00, {7'h0, watchdogRestart});
        @(posedge clk);
        clkEn <= 1'b0;
        i_host.wr(CPR_OFS_TEMP, 8'h00);
        clkEn <= 1'b1;
        rc("frozen", CPR_OFS_TEMP, 8'h96);
        i_host.wr(CPR_OFS_TEMP, 8'h55);
        @(posedge clk);
        rst_b <= 1'b0;
        @(posedge clk);
        rst_b <= 1'b1;
        rc("rst again", CPR_OFS_TEMP, 8'h96);
        summarize();
    end

    // a hang counts as a mismatch
    initial begin
        #1000000;
        fail_count++;
        summarize();
    end
endmodule : charger_power_path_mppt_ts_regs_tb_top
